// >>> verilog/ldms_mode_sequencer.v
// Purpose: Operating-mode sequencer and boost control of an RGB LED driver
// Assumes: Register port is the decoded serial port, on clk_sys
// Notes:   Analog indications arrive asynchronously and are synchronised
//
// How it works
// - Reset clears every register to default, then the device goes standby.
// - Standby-release bit reads zero after any reset.
// - Reset on reset-register write, power-on reset, or low reset pin.
// - Any data written to the reset register address resets the device.
// - Power-on reset holds reset; on release the device proceeds to standby.
// - Release bit zero keeps standby with every function disabled.
// - Writes land in standby; boost and active-load bits act once startup completes.
// - Setting release bit runs startup: reference, oscillator, fixed settle.
// - Thermal shutdown disables operation and holds startup until cleared.
// - Boost startup after startup if enabled, or on enable write.
// - Boost startup ramps the output in PWM over a timed delay.
// - Every LED output forced off throughout boost startup.
// - Normal mode accepts writes in any order, many bits at once.
// - Eight-bit voltage register maps onto nine discrete steps.
// - Three switching frequencies from the oscillator; highest by default.
// - All timing derives from the single oscillator and scales with it.
// - A minimum-length switching pulse is issued every cycle that is not skipped.
// - Active-load bit switches active load; off allows pulse skipping.
// - Voltage value selects the feedback divider setting.
// - Writing boost enable to zero stops the boost converter.
// - Frequency register has its own address and fixed reset default.
`timescale 1ns/1ps
`include "ldms_regs.vh"

module ldms_mode_sequencer #(
    parameter integer START_CYC  = `LDMS_START_CYC,
    parameter integer BSTART_CYC = `LDMS_BSTART_CYC,
    parameter integer CNT_W      = 18
) (
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire       regWrEn,
    input  wire [7:0] regWrAddr,
    input  wire [7:0] regWrData,
    input  wire [7:0] regRdAddr,
    output reg  [7:0] regRdData,
    input  wire       porActive,
    input  wire       externalResetPinN,
    input  wire       thermalShutdownFlag,
    input  wire       currentTrip,
    input  wire       outputHigh,
    output reg  [2:0] modeState,
    output reg        refOscOn,
    output reg        ledForceOff,
    output reg        boostRun,
    output reg        boostGate,
    output reg        activeLoadOn,
    output reg  [3:0] fbDividerSel,
    output reg  [1:0] boostFreqSel
);

    // Periods in oscillator cycles, cut on purpose to the phase width
    localparam integer PER_LOW_I  = `LDMS_PER_LOW;
    localparam integer PER_MID_I  = `LDMS_PER_MID;
    localparam integer PER_HIGH_I = `LDMS_PER_HIGH;
    localparam [4:0]   PER_LOW    = PER_LOW_I[4:0];
    localparam [4:0]   PER_MID    = PER_MID_I[4:0];
    localparam [4:0]   PER_HIGH   = PER_HIGH_I[4:0];

    // Nine feedback steps: floor(val * 9 / 256)
    function [3:0] voltStep;
        input [7:0] val;
        reg   [11:0] prod;
        begin
            prod     = {4'h0, val} * 12'h009;
            voltStep = prod[11:8];
        end
    endfunction

    function [4:0] periodOf;
        input [1:0] sel;
        begin
            case (sel)
                `LDMS_FSEL_LOW: periodOf = PER_LOW;
                `LDMS_FSEL_MID: periodOf = PER_MID;
                default:        periodOf = PER_HIGH;
            endcase
        end
    endfunction

    // Boost may run in these two states only
    function inRun;
        input [2:0] st;
        begin
            inRun = (st == `LDMS_ST_BSTART) ||
                    (st == `LDMS_ST_NORMAL);
        end
    endfunction

    // Integer bounds cut to the counter width on purpose
    localparam integer     START_LAST_I  = START_CYC - 1;
    localparam integer     BSTART_LAST_I = BSTART_CYC - 1;
    localparam [CNT_W-1:0] START_LAST    = START_LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] BSTART_LAST   = BSTART_LAST_I[CNT_W-1:0];
    localparam [CNT_W-1:0] CNT_ONE       = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam [CNT_W-1:0] CNT_MAX       = {CNT_W{1'b1}};

    // Synchroniser bit positions; pin idles high, others low
    localparam integer SY_POR  = 0;
    localparam integer SY_RST  = 1;
    localparam integer SY_TSD  = 2;
    localparam integer SY_TRIP = 3;
    localparam [3:0]   SY_IDLE = 4'h2;

    // Two-stage synchronisers; stage one is read only by stage two
    reg  [3:0] syncA_r;
    reg  [3:0] syncB_r;
    wire       porS    = syncB_r[SY_POR];
    wire       extRstS = ~syncB_r[SY_RST];
    wire       tsdS    = syncB_r[SY_TSD];
    wire       tripS   = syncB_r[SY_TRIP];
    reg        vhighA_r;
    reg        vhighB_r;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            syncA_r  <= SY_IDLE;
            syncB_r  <= SY_IDLE;
            vhighA_r <= 1'b0;
            vhighB_r <= 1'b0;
        end else begin
            syncA_r  <= {currentTrip, thermalShutdownFlag,
                         externalResetPinN, porActive};
            syncB_r  <= syncA_r;
            vhighA_r <= outputHigh;
            vhighB_r <= vhighA_r;
        end
    end

    reg  [7:0]       freqReg_r;
    reg  [7:0]       enReg_r;
    reg  [7:0]       voutReg_r;
    reg              softRst_r;
    reg  [2:0]       state_r;
    reg  [2:0]       state_nxt;
    reg  [CNT_W-1:0] cnt_r;
    reg  [4:0]       phase_r;
    reg              pulseOn_r;

    wire wrEnables = regWrEn && (regWrAddr == `LDMS_ADDR_ENABLES);
    wire stbyRel   = enReg_r[`LDMS_EN_STBY_BIT];
    wire boostEn   = enReg_r[`LDMS_EN_BOOST_BIT];
    wire aloadEn   = enReg_r[`LDMS_EN_ALOAD_BIT];
    wire boostRise = wrEnables && regWrData[`LDMS_EN_BOOST_BIT]
                     && !boostEn;
    // Any source alone forces reset; release waits for the last one
    wire anyReset  = porS || extRstS || softRst_r;
    wire [1:0] fSel = freqReg_r[`LDMS_FREQ_MSB:`LDMS_FREQ_LSB];
    wire [4:0] period = periodOf(fSel);
    wire [7:0] statusWord = {4'h0, tsdS, state_r};

    // Registers; a source still active keeps every value at default
    // Writes in reset are dropped; the host must wait for standby
    // Pending soft reset lasts one cycle; the reset branch clears it
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            freqReg_r <= `LDMS_RST_FREQ;
            enReg_r   <= `LDMS_RST_ENABLES;
            voutReg_r <= `LDMS_RST_VOUT;
            softRst_r <= 1'b0;
        end else if (anyReset || state_r == `LDMS_ST_RESET) begin
            freqReg_r <= `LDMS_RST_FREQ;
            enReg_r   <= `LDMS_RST_ENABLES;
            voutReg_r <= `LDMS_RST_VOUT;
            softRst_r <= 1'b0;
        end else if (regWrEn) begin
            case (regWrAddr)
                `LDMS_ADDR_FREQ:    freqReg_r <= regWrData;
                `LDMS_ADDR_ENABLES: enReg_r   <= regWrData;
                `LDMS_ADDR_VOUT:    voutReg_r <= regWrData;
                `LDMS_ADDR_RESET:   softRst_r <= 1'b1;
                default:            softRst_r <= 1'b0;
            endcase
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            `LDMS_ST_RESET:
                if (!anyReset)
                    state_nxt = `LDMS_ST_STANDBY;
            `LDMS_ST_STANDBY:
                if (stbyRel)
                    state_nxt = `LDMS_ST_STARTUP;
            `LDMS_ST_STARTUP:
                if (!stbyRel)
                    state_nxt = `LDMS_ST_STANDBY;
                else if (!tsdS && cnt_r == START_LAST)
                    state_nxt = boostEn ? `LDMS_ST_BSTART
                                        : `LDMS_ST_NORMAL;
            `LDMS_ST_BSTART:
                if (!stbyRel)
                    state_nxt = `LDMS_ST_STANDBY;
                else if (tsdS)
                    state_nxt = `LDMS_ST_STARTUP;
                else if (!boostEn || cnt_r == BSTART_LAST)
                    state_nxt = `LDMS_ST_NORMAL;
            `LDMS_ST_NORMAL:
                if (!stbyRel)
                    state_nxt = `LDMS_ST_STANDBY;
                else if (tsdS)
                    state_nxt = `LDMS_ST_STARTUP;
                else if (boostRise)
                    state_nxt = `LDMS_ST_BSTART;
            default:
                state_nxt = `LDMS_ST_RESET;
        endcase
        if (anyReset)
            state_nxt = `LDMS_ST_RESET;
    end

    // Delay counter restarts on every state change, and while overheated
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= `LDMS_ST_RESET;
            cnt_r   <= {CNT_W{1'b0}};
        end else begin
            state_r <= state_nxt;
            if (state_nxt != state_r || tsdS)
                cnt_r <= {CNT_W{1'b0}};
            else if (cnt_r != CNT_MAX)
                cnt_r <= cnt_r + CNT_ONE;
        end
    end

    // Boost switching, all timing from the one oscillator clock
    wire inBst     = (state_r == `LDMS_ST_BSTART);
    wire boostOk   = boostEn && !tsdS && inRun(state_r);
    wire [4:0] maxOn = period - `LDMS_OFF_GUARD;
    // Soft start: on-time limit climbs in sixteen steps over the delay
    // Short delay counts keep the ramp at its minimum on-time
    wire [4:0] ssOn  = `LDMS_MIN_ON + {1'b0, cnt_r[CNT_W-1:CNT_W-4]};
    wire [4:0] onLim = (inBst && ssOn < maxOn) ? ssOn : maxOn;
    wire periodEnd = (phase_r >= period - 5'h01);
    // Skipping allowed only when active load is disabled
    wire skip      = !aloadEn && vhighB_r;
    // Gate ends at the on-limit, or on trip once the minimum is served
    wire gateOff   = (phase_r + 5'h01 >= onLim) ||
                     (tripS && phase_r + 5'h01 >= `LDMS_MIN_ON);

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phase_r   <= 5'h00;
            pulseOn_r <= 1'b0;
        end else if (!boostOk) begin
            phase_r   <= 5'h00;
            pulseOn_r <= 1'b0;
        end else if (periodEnd) begin
            phase_r   <= 5'h00;
            pulseOn_r <= !skip;
        end else begin
            phase_r   <= phase_r + 5'h01;
            if (gateOff)
                pulseOn_r <= 1'b0;
        end
    end

    // Registered outputs
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            modeState    <= `LDMS_ST_RESET;
            refOscOn     <= 1'b0;
            ledForceOff  <= 1'b1;
            boostRun     <= 1'b0;
            boostGate    <= 1'b0;
            activeLoadOn <= 1'b0;
            fbDividerSel <= 4'h0;
            boostFreqSel <= 2'h3;
            regRdData    <= 8'h00;
        end else begin
            modeState    <= state_r;
            refOscOn     <= state_r == `LDMS_ST_STARTUP ||
                            inRun(state_r);
            ledForceOff  <= state_r != `LDMS_ST_NORMAL ||
                            tsdS;
            boostRun     <= boostOk;
            boostGate    <= pulseOn_r && boostOk;
            activeLoadOn <= boostOk && aloadEn;
            fbDividerSel <= voltStep(voutReg_r);
            boostFreqSel <= fSel;
            // Readback one edge after the address; unmapped reads zero
            case (regRdAddr)
                `LDMS_ADDR_FREQ:    regRdData <= freqReg_r;
                `LDMS_ADDR_ENABLES: regRdData <= enReg_r;
                `LDMS_ADDR_VOUT:    regRdData <= voutReg_r;
                `LDMS_ADDR_STATUS:  regRdData <= statusWord;
                default:            regRdData <= 8'h00;
            endcase
        end
    end

endmodule

// >>> verilog/ldms_regs.vh
// Purpose: Constants for the LED driver mode sequencer
// Assumes: clk_sys at 25 MHz is the internal oscillator time base
// Notes:   Offsets are byte addresses on the serial register port
`ifndef LDMS_REGS_VH
`define LDMS_REGS_VH

`define LDMS_CLK_HZ        25000000
`define LDMS_T_START_US    10000
`define LDMS_T_BSTART_US   10000
`define LDMS_START_CYC     (`LDMS_T_START_US * (`LDMS_CLK_HZ / 1000000))
`define LDMS_BSTART_CYC    (`LDMS_T_BSTART_US * (`LDMS_CLK_HZ / 1000000))

`define LDMS_F_LOW_HZ      1000000
`define LDMS_F_MID_HZ      1670000
`define LDMS_F_HIGH_HZ     2000000
`define LDMS_PER_LOW       (`LDMS_CLK_HZ / `LDMS_F_LOW_HZ)
`define LDMS_PER_MID       (`LDMS_CLK_HZ / `LDMS_F_MID_HZ)
`define LDMS_PER_HIGH      (`LDMS_CLK_HZ / `LDMS_F_HIGH_HZ)
`define LDMS_MIN_ON        5'h02
`define LDMS_OFF_GUARD     5'h02

`define LDMS_ADDR_FREQ     8'h10
`define LDMS_ADDR_ENABLES  8'h11
`define LDMS_ADDR_VOUT     8'h14
`define LDMS_ADDR_STATUS   8'h15
`define LDMS_ADDR_RESET    8'h60

`define LDMS_EN_STBY_BIT   7
`define LDMS_EN_BOOST_BIT  6
`define LDMS_EN_ALOAD_BIT  0
`define LDMS_FREQ_LSB      0
`define LDMS_FREQ_MSB      1

`define LDMS_RST_FREQ      8'h07
`define LDMS_RST_ENABLES   8'h01
`define LDMS_RST_VOUT      8'h00

`define LDMS_FSEL_LOW      2'h0
`define LDMS_FSEL_MID      2'h1

`define LDMS_ST_RESET      3'h0
`define LDMS_ST_STANDBY    3'h1
`define LDMS_ST_STARTUP    3'h2
`define LDMS_ST_BSTART     3'h3
`define LDMS_ST_NORMAL     3'h4

`endif

// >>> tb/ldms_host_model.sv
// Purpose: Host model driving the decoded register port
// Assumes: One byte per write strobe, changes on falling edges
// Notes:   Released write lines show inverted data, never stale values
`timescale 1ns/1ps
module ldms_host_model (
    input  wire       clk_sys,
    input  wire [7:0] regRdData,
    output reg        regWrEn,
    output reg  [7:0] regWrAddr,
    output reg  [7:0] regWrData,
    output reg  [7:0] regRdAddr
);
    initial {regWrEn, regWrAddr, regWrData, regRdAddr} = 25'h0000000;
    // Any address order, data written whole in one strobe
    task wr(input [7:0] a, input [7:0] dat);
        @(negedge clk_sys);
        {regWrEn, regWrAddr, regWrData} = {1'b1, a, dat};
        @(negedge clk_sys);
        {regWrEn, regWrAddr, regWrData} = {1'b0, ~a, ~dat};
    endtask
    task rd(input [7:0] a, output [7:0] dat);
        @(negedge clk_sys);
        regRdAddr = a;
        @(negedge clk_sys);
        dat = regRdData;
    endtask
endmodule

// >>> tb/ldms_seq_sva.sv
// Purpose: Port assertions for the mode sequencer
// Assumes: START_CYC matches the bound instance
// Notes:   Sync delay of two flops allowed for
`timescale 1ns/1ps
module ldms_seq_chk #(
    parameter integer START_CYC = 40
) (
    input wire       clk_sys,
    input wire       rst_b,
    input wire       porActive,
    input wire       externalResetPinN,
    input wire       thermalShutdownFlag,
    input wire [2:0] modeState,
    input wire       refOscOn,
    input wire       ledForceOff,
    input wire       boostRun,
    input wire       boostGate,
    input wire       activeLoadOn,
    input wire [3:0] fbDividerSel,
    input wire [1:0] boostFreqSel
);
    reg [17:0] stCnt_r;
    // Raw flag restarts early, hence slack of four
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b)
            stCnt_r <= 18'h00000;
        else if (modeState != 3'h2 || thermalShutdownFlag)
            stCnt_r <= 18'h00000;
        else
            stCnt_r <= stCnt_r + 18'h00001;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    AST_POR_HOLD: assert property (porActive [*6] |-> modeState == 3'h0)
        else $error("reset not held by power-on");
    AST_PIN_HOLD: assert property (!externalResetPinN [*6] |->
        modeState == 3'h0 && !refOscOn) else $error("reset not held by pin");
    AST_DEFAULTS: assert property ((modeState == 3'h0) [*3] |->
        boostFreqSel == 2'h3 && fbDividerSel == 4'h0)
        else $error("registers not at default in reset");
    AST_BST_LEDOFF: assert property (modeState == 3'h3 |-> ledForceOff)
        else $error("led outputs on in boost startup");
    AST_IDLE_OFF: assert property (modeState <= 3'h1 |->
        !refOscOn && !boostRun) else $error("functions active in standby");
    AST_GATE_MIN: assert property ($rose(boostGate) && boostRun |=>
        boostGate || !boostRun) else $error("gate pulse under two cycles");
    AST_ALOAD: assert property (activeLoadOn |-> boostRun)
        else $error("active load without boost");
    AST_START_LEN: assert property (stCnt_r <= START_CYC + 4)
        else $error("startup delay too long");
endmodule
bind ldms_mode_sequencer ldms_seq_chk #(.START_CYC(START_CYC)) i_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .porActive(porActive),
    .externalResetPinN(externalResetPinN), .modeState(modeState),
    .thermalShutdownFlag(thermalShutdownFlag), .refOscOn(refOscOn),
    .ledForceOff(ledForceOff), .boostRun(boostRun), .boostGate(boostGate),
    .activeLoadOn(activeLoadOn), .fbDividerSel(fbDividerSel),
    .boostFreqSel(boostFreqSel));

// >>> tb/ldms_mode_sequencer_tb_top.sv
// Purpose: Self-checking bench for the mode sequencer
// Assumes: Short startup counts, inputs move on falling edges
// Notes:   Random data from an LFSR
`timescale 1ns/1ps
`include "ldms_regs.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
    $display("unexpected %s exp %0h got %0h", n, e, s); end end
module ldms_mode_sequencer_tb_top;
    localparam integer ST = 40;
    localparam integer BS = 40;
    reg         clk_sys = 1'b0;
    reg         rst_b, porActive, externalResetPinN;
    reg         thermalShutdownFlag, currentTrip, outputHigh;
    wire        regWrEn, refOscOn, ledForceOff, boostRun, boostGate;
    wire        activeLoadOn;
    wire [7:0]  regWrAddr, regWrData, regRdAddr, regRdData;
    wire [2:0]  modeState;
    wire [3:0]  fbDividerSel;
    wire [1:0]  boostFreqSel;
    reg  [31:0] lfsr = 32'h0000AC30;
    reg  [7:0]  d;
    integer     checks = 0, failures = 0, n, i;
    always #20 clk_sys = ~clk_sys;
    ldms_mode_sequencer #(.START_CYC(ST), .BSTART_CYC(BS))
    i_ldms_mode_sequencer (.clk_sys(clk_sys), .rst_b(rst_b),
        .regWrEn(regWrEn), .regWrAddr(regWrAddr), .regWrData(regWrData),
        .regRdAddr(regRdAddr), .regRdData(regRdData),
        .porActive(porActive), .externalResetPinN(externalResetPinN),
        .thermalShutdownFlag(thermalShutdownFlag),
        .currentTrip(currentTrip), .outputHigh(outputHigh),
        .modeState(modeState), .refOscOn(refOscOn),
        .ledForceOff(ledForceOff), .boostRun(boostRun),
        .boostGate(boostGate), .activeLoadOn(activeLoadOn),
        .fbDividerSel(fbDividerSel), .boostFreqSel(boostFreqSel));
    ldms_host_model i_ldms_host_model (.clk_sys(clk_sys),
        .regRdData(regRdData), .regWrEn(regWrEn), .regWrAddr(regWrAddr),
        .regWrData(regWrData), .regRdAddr(regRdAddr));
    function [31:0] nextRnd(input [31:0] s);
        nextRnd = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function [3:0] fbExp(input [7:0] v);
        reg [11:0] p;
        begin
            p = {4'h0, v} * 12'h009;
            fbExp = p[11:8];
        end
    endfunction
    task waitMode(input [2:0] m);
        integer k;
        for (k = 0; k < 500 && modeState !== m; k++) @(negedge clk_sys);
        `CHK("mode", m, modeState)
    endtask
    task dwell(input [2:0] m, output integer c);
        waitMode(m);
        for (c = 0; c < 500 && modeState === m; c++) @(negedge clk_sys);
    endtask
    task pulses(output integer c);
        integer k;
        c = 0;
        for (k = 0; k < 40; k++) begin
            @(negedge clk_sys);
            lfsr = nextRnd(lfsr);
            currentTrip = lfsr[5];
            c = c + (boostGate === 1'b1);
        end
    endtask
    task summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Whole sequence needs well under a thousand cycles
    initial begin
        #160000;
        failures++;
        summarize;
    end
    initial begin
        {rst_b, porActive, thermalShutdownFlag, currentTrip} = 4'h0;
        {externalResetPinN, outputHigh} = 2'h2;
        repeat (6) @(negedge clk_sys);
        rst_b = 1'b1;
        waitMode(`LDMS_ST_STANDBY);
        i_ldms_host_model.rd(`LDMS_ADDR_ENABLES, d);
        `CHK("enables", `LDMS_RST_ENABLES, d)
        i_ldms_host_model.rd(`LDMS_ADDR_FREQ, d);
        `CHK("freq", `LDMS_RST_FREQ, d)
        i_ldms_host_model.wr(`LDMS_ADDR_VOUT, 8'hFF);
        `CHK("osc", 1'b0, refOscOn)
        i_ldms_host_model.wr(`LDMS_ADDR_ENABLES, 8'hC1);
        dwell(`LDMS_ST_STARTUP, n);
        `CHK("startup", ST, n)
        `CHK("ledoff", 1'b1, ledForceOff)
        dwell(`LDMS_ST_BSTART, n);
        `CHK("bstart", BS, n)
        `CHK("fb", 4'h8, fbDividerSel)
        `CHK("ledoff", 1'b0, ledForceOff)
        for (i = 0; i < 8; i++) begin
            lfsr = nextRnd(lfsr);
            i_ldms_host_model.wr(`LDMS_ADDR_VOUT, lfsr[7:0]);
            i_ldms_host_model.wr(`LDMS_ADDR_FREQ, {lfsr[15:10], i[1:0]});
            @(negedge clk_sys);
            `CHK("fb", fbExp(lfsr[7:0]), fbDividerSel)
            `CHK("fsel", i[1:0], boostFreqSel)
        end
        i_ldms_host_model.rd(`LDMS_ADDR_STATUS, d);
        `CHK("status", {5'h00, `LDMS_ST_NORMAL}, d)
        outputHigh = 1'b1;
        pulses(n);
        `CHK("pulse", 1'b1, n > 0)
        `CHK("aload", 1'b1, activeLoadOn)
        i_ldms_host_model.wr(`LDMS_ADDR_ENABLES, 8'hC0);
        pulses(n);
        pulses(n);
        `CHK("skip", 0, n)
        `CHK("aload", 1'b0, activeLoadOn)
        outputHigh = 1'b0;
        i_ldms_host_model.wr(`LDMS_ADDR_ENABLES, 8'h80);
        @(negedge clk_sys);
        `CHK("run", 1'b0, boostRun)
        i_ldms_host_model.wr(`LDMS_ADDR_ENABLES, 8'hC0);
        waitMode(`LDMS_ST_BSTART);
        waitMode(`LDMS_ST_NORMAL);
        thermalShutdownFlag = 1'b1;
        waitMode(`LDMS_ST_STARTUP);
        repeat (2 * ST) @(negedge clk_sys);
        `CHK("tsd", `LDMS_ST_STARTUP, modeState)
        i_ldms_host_model.rd(`LDMS_ADDR_STATUS, d);
        `CHK("status", {5'h01, `LDMS_ST_STARTUP}, d)
        thermalShutdownFlag = 1'b0;
        dwell(`LDMS_ST_STARTUP, n);
        `CHK("tsd", 1'b1, n >= ST)
        i_ldms_host_model.wr(`LDMS_ADDR_RESET, lfsr[23:16]);
        waitMode(`LDMS_ST_RESET);
        waitMode(`LDMS_ST_STANDBY);
        i_ldms_host_model.rd(`LDMS_ADDR_ENABLES, d);
        `CHK("enables", `LDMS_RST_ENABLES, d)
        externalResetPinN = 1'b0;
        waitMode(`LDMS_ST_RESET);
        {porActive, externalResetPinN} = 2'h3;
        repeat (10) @(negedge clk_sys);
        `CHK("por", `LDMS_ST_RESET, modeState)
        porActive = 1'b0;
        waitMode(`LDMS_ST_STANDBY);
        summarize;
    end
endmodule
